// *** rtl/scrc_consts.svh ***
`ifndef SCRC_CONSTS_SVH
`define SCRC_CONSTS_SVH

// ==========================================
// Register offsets
`define SCRC_ADDR_CHKRB 4'h6
`define SCRC_ADDR_SWCTL 4'h7
`define SCRC_ADDR_OUTEN 4'h8
`define SCRC_ADDR_ALARM 4'h9

// ==========================================
// Reset values and field positions
`define SCRC_RST_WORD   16'h0000
`define SCRC_SW_FLAG    8
`define SCRC_SW_DLY     7
`define SCRC_SW_LOCK_HI 6
`define SCRC_SW_LOCK_LO 4
`define SCRC_SW_BANK_HI 2
`define SCRC_SW_BANK_LO 0
`define SCRC_CNT_HI     7
`define SCRC_LOCK_RAM   3'h5
`define SCRC_BANK_NONE  3'h0
`define SCRC_FAULT_REF_SELECT    15
`define SCRC_FLT_THR    12

// ==========================================
// Timing
`define SCRC_CLK_KHZ  20000
`define SCRC_TICK_MS  10
`define SCRC_WATCH_MS 1000

`endif

// *** rtl/scrc_pkg.sv ***
package scrc_pkg;

	typedef enum logic [1:0] {
		ST_DRIVE = 2'b00,
		ST_COUNT = 2'b01,
		ST_QUIET = 2'b10
	} scrc_oe_state_t;

	typedef enum logic [1:0] {
		CK_CLEAR = 2'b00,
		CK_ADD   = 2'b01,
		CK_FIN   = 2'b10
	} scrc_ck_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} scrc_req_t;

	typedef struct packed {
		logic [15:0] zero_offset_dac;
		logic [15:0] gain_trim_dac;
		logic [15:0] fault_config_word;
		logic [15:0] misc_config_word;
	} scrc_cal_t;

	typedef struct packed {
		logic amp1_sat_high;
		logic amp1_sat_low;
		logic amp2_sat_high;
		logic amp2_sat_low;
		logic amp3_sat_low;
		logic neg_input_over;
		logic neg_input_under;
		logic pos_input_over;
		logic pos_input_under;
	} scrc_alarm_t;

endpackage

// *** rtl/scrc_checksum.sv ***
`timescale 1ns/1ps
`include "scrc_consts.svh"

module scrc_checksum (
	input  wire logic              i_clk,   // Reference clock
	input  wire logic              i_rst,   // Sync reset, high
	input  wire scrc_pkg::scrc_cal_t i_cal, // Covered calibration words
	output logic                   o_done,  // One-cycle result strobe
	output logic [15:0]            o_sum    // Inverted end-around sum
);
	import scrc_pkg::*;

	scrc_ck_state_t state_q;
	logic [1:0]     idx_q;
	logic [15:0]    acc_q;
	logic [15:0]    word;
	logic [16:0]    sum17;

	always_comb begin
		case (idx_q)
			2'd0: word = i_cal.zero_offset_dac;
			2'd1: word = i_cal.gain_trim_dac;
			2'd2: word = i_cal.fault_config_word;
			default: word = i_cal.misc_config_word;
		endcase
		sum17 = {1'b0, acc_q} + {1'b0, word};
	end

	// ==========================================
	// Free-running pass, so the result tracks RAM edits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= CK_CLEAR;
			idx_q   <= 2'd0;
			acc_q   <= 16'h0000;
			o_done  <= 1'b0;
			o_sum   <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			case (state_q)
				CK_CLEAR: begin
					acc_q   <= 16'h0000;
					idx_q   <= 2'd0;
					state_q <= CK_ADD;
				end
				CK_ADD: begin
					acc_q <= sum17[15:0] + {15'h0000, sum17[16]};
					idx_q <= idx_q + 2'd1;
					if (idx_q == 2'd3) begin
						state_q <= CK_FIN;
					end
				end
				CK_FIN: begin
					o_sum   <= ~acc_q;
					o_done  <= 1'b1;
					state_q <= CK_CLEAR;
				end
				default: state_q <= CK_CLEAR;
			endcase
		end
	end

endmodule

// *** rtl/scrc_regs.sv ***
`timescale 1ns/1ps
`include "scrc_consts.svh"


module scrc_regs #(
	parameter int TICK_CYCLES  = `SCRC_TICK_MS * `SCRC_CLK_KHZ,  // 10 ms in clocks
	parameter int WATCH_CYCLES = `SCRC_WATCH_MS * `SCRC_CLK_KHZ  // 1 s in clocks
) (
	input  wire logic                 I_REF_CLK,         // 20 MHz clock
	input  wire logic                 I_SYS_RST,         // Sync reset, high
	input  wire scrc_pkg::scrc_req_t  I_REQ,             // Register access from link
	input  wire scrc_pkg::scrc_cal_t  I_CAL,             // Calibration words
	input  wire logic [15:0]          I_STORED_STORED_CHECKSUM,     // Stored checksum word
	input  wire scrc_pkg::scrc_alarm_t I_ALARM,          // Fault comparator levels
	input  wire logic                 I_OW_VALID_TXN,    // Valid addressed transaction
	output logic [15:0]               O_RDATA,           // Read data
	output logic                      O_RVALID,          // Read data strobe
	output logic                      O_TURNAROUND_8BIT, // Reply gap select
	output logic                      O_RUN_FROM_RAM,    // Lock mode active
	output logic                      O_OTP_LOAD_REQ,    // Bank copy request pulse
	output logic [2:0]                O_OTP_BANK,        // Bank to copy
	output logic                      O_VOUT_EN,         // Analog driver enable
	output logic                      O_FAULT_REF_SEL,   // Fault reference select
	output logic                      O_FAULT_THR_SEL    // Fault threshold select
);
	import scrc_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int WW = $clog2(WATCH_CYCLES + 1);

	// ==========================================
	// Declarations
	logic [15:0]    checksum_readback_q;
	logic           checksum_ok_flag_q;
	logic           turnaround_delay_select_q;
	logic [2:0]     lock_mode_field_q;
	logic [2:0]     otp_bank_select_q;
	logic [7:0]     vout_enable_count_q;
	scrc_alarm_t    fault_alarm_flags_q;
	scrc_oe_state_t state_q;
	logic [TW-1:0]  tick_cnt_q;
	logic [WW-1:0]  watch_cnt_q;
	logic           vout_en_q;
	logic           ck_done;
	logic [15:0]    ck_sum;
	logic           chk_wr;
	logic           sw_wr;
	logic           out_wr;
	logic           tick_end;
	logic           watch_end;
	logic [15:0]    software_control;
	logic [15:0]    rdata_d;

	assign chk_wr    = I_REQ.wr && (I_REQ.addr == `SCRC_ADDR_CHKRB);
	assign sw_wr     = I_REQ.wr && (I_REQ.addr == `SCRC_ADDR_SWCTL);
	assign out_wr    = I_REQ.wr && (I_REQ.addr == `SCRC_ADDR_OUTEN);
	assign tick_end  = (tick_cnt_q == TW'(TICK_CYCLES - 1));
	assign watch_end = (watch_cnt_q == WW'(WATCH_CYCLES - 1));

	// ==========================================
	// Checksum engine
	scrc_checksum u_checksum (
		.i_clk  (I_REF_CLK),
		.i_rst  (I_SYS_RST),
		.i_cal  (I_CAL),
		.o_done (ck_done),
		.o_sum  (ck_sum)
	);

	// Hardware result wins over a software write in the same cycle
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			checksum_readback_q <= `SCRC_RST_WORD;
		end else if (ck_done) begin
			checksum_readback_q <= ck_sum;
		end else if (chk_wr) begin
			checksum_readback_q <= I_REQ.wdata;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			checksum_ok_flag_q <= 1'b0;
		end else if (ck_done) begin
			checksum_ok_flag_q <= (ck_sum == I_STORED_STORED_CHECKSUM);
		end
	end

	// ==========================================
	// Software control
	// Reserved bits are never stored, so a careless write cannot corrupt them
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			turnaround_delay_select_q <= 1'b0;
			lock_mode_field_q         <= 3'h0;
			otp_bank_select_q         <= `SCRC_BANK_NONE;
		end else if (sw_wr) begin
			turnaround_delay_select_q <= I_REQ.wdata[`SCRC_SW_DLY];
			lock_mode_field_q <= I_REQ.wdata[`SCRC_SW_LOCK_HI:`SCRC_SW_LOCK_LO];
			otp_bank_select_q <= I_REQ.wdata[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_TURNAROUND_8BIT <= 1'b0;
			O_RUN_FROM_RAM    <= 1'b0;
		end else begin
			O_TURNAROUND_8BIT <= turnaround_delay_select_q;
			O_RUN_FROM_RAM    <= (lock_mode_field_q == `SCRC_LOCK_RAM);
		end
	end

	// Bank copy is requested once per control write carrying the lock pattern and a nonzero bank
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_OTP_LOAD_REQ <= 1'b0;
			O_OTP_BANK     <= `SCRC_BANK_NONE;
		end else begin
			O_OTP_LOAD_REQ <= 1'b0;
			if (sw_wr && I_REQ.wdata[`SCRC_SW_LOCK_HI:`SCRC_SW_LOCK_LO] == `SCRC_LOCK_RAM) begin
				O_OTP_BANK <= I_REQ.wdata[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO];
				if (I_REQ.wdata[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO] != `SCRC_BANK_NONE) begin
					O_OTP_LOAD_REQ <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Output enable counter and activity watch
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			state_q             <= ST_DRIVE;
			vout_enable_count_q <= 8'h00;
			vout_en_q           <= 1'b1;
		end else begin
			case (state_q)
				ST_DRIVE: begin
					if (out_wr && I_REQ.wdata[`SCRC_CNT_HI:0] != 8'h00) begin
						vout_enable_count_q <= I_REQ.wdata[`SCRC_CNT_HI:0];
						state_q             <= ST_COUNT;
					end
				end
				ST_COUNT: begin
					if (out_wr) begin
						vout_enable_count_q <= I_REQ.wdata[`SCRC_CNT_HI:0];
						if (I_REQ.wdata[`SCRC_CNT_HI:0] == 8'h00) begin
							vout_en_q <= 1'b0;
							state_q   <= ST_QUIET;
						end
					end else if (tick_end) begin
						vout_enable_count_q <= vout_enable_count_q - 8'h01;
						if (vout_enable_count_q == 8'h01) begin
							vout_en_q <= 1'b0;
							state_q   <= ST_QUIET;
						end
					end
				end
				ST_QUIET: begin
					if (out_wr && I_REQ.wdata[`SCRC_CNT_HI:0] != 8'h00) begin
						vout_enable_count_q <= I_REQ.wdata[`SCRC_CNT_HI:0];
						vout_en_q           <= 1'b1;
						state_q             <= ST_COUNT;
					end else if (watch_end && !I_OW_VALID_TXN) begin
						vout_en_q <= 1'b1;
						state_q   <= ST_DRIVE;
					end
				end
				default: begin
					vout_en_q <= 1'b1;
					state_q   <= ST_DRIVE;
				end
			endcase
		end
	end

	// Tick restarts on every load so the first step is a full 10 ms
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			tick_cnt_q <= '0;
		end else if (state_q != ST_COUNT || out_wr || tick_end) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			watch_cnt_q <= '0;
		end else if (state_q != ST_QUIET || I_OW_VALID_TXN || watch_end) begin
			watch_cnt_q <= '0;
		end else begin
			watch_cnt_q <= watch_cnt_q + WW'(1);
		end
	end

	assign O_VOUT_EN = vout_en_q;

	// ==========================================
	// Alarm and fault configuration
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			fault_alarm_flags_q <= '0;
			O_FAULT_REF_SEL     <= 1'b0;
			O_FAULT_THR_SEL     <= 1'b0;
		end else begin
			fault_alarm_flags_q <= I_ALARM;
			O_FAULT_REF_SEL     <= I_CAL.fault_config_word[`SCRC_FAULT_REF_SELECT];
			O_FAULT_THR_SEL     <= I_CAL.fault_config_word[`SCRC_FLT_THR];
		end
	end

	// ==========================================
	// Read path
	always_comb begin
		software_control = 16'h0000;
		software_control[`SCRC_SW_FLAG] = checksum_ok_flag_q;
		software_control[`SCRC_SW_DLY]  = turnaround_delay_select_q;
		software_control[`SCRC_SW_LOCK_HI:`SCRC_SW_LOCK_LO] = lock_mode_field_q;
		software_control[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO] = otp_bank_select_q;
		case (I_REQ.addr)
			`SCRC_ADDR_CHKRB: rdata_d = checksum_readback_q;
			`SCRC_ADDR_SWCTL: rdata_d = software_control;
			`SCRC_ADDR_OUTEN: rdata_d = {8'h00, vout_enable_count_q};
			`SCRC_ADDR_ALARM: rdata_d = {7'h00, fault_alarm_flags_q};
			default:          rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_RDATA  <= 16'h0000;
			O_RVALID <= 1'b0;
		end else begin
			O_RVALID <= I_REQ.rd;
			if (I_REQ.rd) begin
				O_RDATA <= rdata_d;
			end
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_SYS_RST);

	sequence s_last_tick;
		state_q == ST_COUNT && tick_end && vout_enable_count_q == 8'h01 && !out_wr;
	endsequence

	sequence s_quiet_start;
		state_q == ST_QUIET && watch_cnt_q == '0 && !O_VOUT_EN;
	endsequence

	sequence s_silent_expiry;
		state_q == ST_QUIET && watch_end && !I_OW_VALID_TXN && !out_wr;
	endsequence

	a_checksum_copy: assert property (
		ck_done |=> checksum_readback_q == $past(ck_sum)
	) else $error("checksum readback not updated");

	a_flag_match: assert property (
		ck_done |=> checksum_ok_flag_q == ($past(ck_sum) == $past(I_STORED_STORED_CHECKSUM))
	) else $error("checksum flag wrong");

	a_delay_select: assert property (
		sw_wr |-> ##2 O_TURNAROUND_8BIT == $past(I_REQ.wdata[`SCRC_SW_DLY], 2)
	) else $error("turnaround select not applied");

	a_lock_mode: assert property (
		sw_wr |-> ##2 O_RUN_FROM_RAM ==
			($past(I_REQ.wdata[`SCRC_SW_LOCK_HI:`SCRC_SW_LOCK_LO], 2) == `SCRC_LOCK_RAM)
	) else $error("lock mode decode wrong");

	a_bank_none: assert property (
		sw_wr && I_REQ.wdata[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO] == `SCRC_BANK_NONE
		|=> !O_OTP_LOAD_REQ
	) else $error("load requested for bank zero");

	a_bank_load: assert property (
		sw_wr && I_REQ.wdata[`SCRC_SW_LOCK_HI:`SCRC_SW_LOCK_LO] == `SCRC_LOCK_RAM
		&& I_REQ.wdata[`SCRC_SW_BANK_HI:`SCRC_SW_BANK_LO] != `SCRC_BANK_NONE
		|=> O_OTP_LOAD_REQ && O_OTP_BANK == $past(I_REQ.wdata[`SCRC_SW_BANK_HI:0])
	) else $error("bank load not requested");

	a_reset_clear: assert property (
		$past(I_SYS_RST) |-> checksum_readback_q == 16'h0000 && !O_RUN_FROM_RAM
		&& vout_enable_count_q == 8'h00 && fault_alarm_flags_q == '0
	) else $error("register not cleared by reset");

	a_count_load: assert property (
		out_wr && I_REQ.wdata[`SCRC_CNT_HI:0] != 8'h00
		|=> vout_enable_count_q == $past(I_REQ.wdata[`SCRC_CNT_HI:0]) && O_VOUT_EN
	) else $error("count load failed");

	a_count_step: assert property (
		state_q == ST_COUNT && tick_end && !out_wr
		|=> vout_enable_count_q == $past(vout_enable_count_q) - 8'h01
	) else $error("count did not decrement");

	a_enable_span: assert property (
		state_q == ST_COUNT && vout_enable_count_q != 8'h00 |-> O_VOUT_EN
	) else $error("output dropped with count left");

	a_quiet_entry: assert property (
		s_last_tick |=> s_quiet_start
	) else $error("watch timer not started at expiry");

	a_txn_hold: assert property (
		state_q == ST_QUIET && I_OW_VALID_TXN && !out_wr |=> s_quiet_start
	) else $error("transaction did not restart watch");

	a_wake_up: assert property (
		s_silent_expiry |=> O_VOUT_EN && state_q == ST_DRIVE
	) else $error("output not re-enabled");

	a_alarm_read: assert property (
		I_REQ.rd && I_REQ.addr == `SCRC_ADDR_ALARM
		|=> O_RVALID && O_RDATA[15:9] == 7'h00 && O_RDATA[8:0] == $past(fault_alarm_flags_q)
	) else $error("alarm read wrong");

endmodule

// *** sim/scrc_ctrl_model.sv ***
`timescale 1ns/1ps
`include "scrc_consts.svh"

// ==========================================
// Outside controller behind the one-wire decoder
module scrc_ctrl_model (
	input  wire logic                i_clk,          // Reference clock
	output scrc_pkg::scrc_req_t      o_req,          // Decoded register access
	output logic                     o_ow_valid_txn  // Valid addressed transaction
);
	import scrc_pkg::*;

	initial begin
		o_req = '0;
		o_ow_valid_txn = 1'b0;
	end

	// One access per call, held across exactly one sampling edge
	task automatic access(input logic wr, input logic [3:0] addr, input logic [15:0] data);
		logic [15:0] d;
		d = data;
		if (addr == `SCRC_ADDR_SWCTL) d = data & 16'h00F7;
		if (addr == `SCRC_ADDR_OUTEN) d = data & 16'h00FF;
		@(negedge i_clk);
		o_req.wr = wr;
		o_req.rd = !wr;
		o_req.addr = addr;
		o_req.wdata = d;
		@(negedge i_clk);
		o_req = '0;
	endtask

	task automatic ping();
		@(negedge i_clk);
		o_ow_valid_txn = 1'b1;
		@(negedge i_clk);
		o_ow_valid_txn = 1'b0;
	endtask
endmodule

// *** sim/scrc_regs_tb.sv ***
`timescale 1ns/1ps
`include "scrc_consts.svh"

module scrc_regs_tb;
	import scrc_pkg::*;
	localparam int TICK  = 8;
	localparam int WATCH = 40;

	logic        clk;
	logic        rst;
	scrc_req_t   req;
	scrc_cal_t   cal;
	logic [15:0] stored;
	scrc_alarm_t alarm;
	logic        ow_txn;
	logic [15:0] rdata;
	logic        rvalid;
	logic        dly8;
	logic        ram;
	logic        load;
	logic [2:0]  bank;
	logic        en;
	logic        fref;
	logic        fthr;
	int          miscompares;
	int          tests_run;
	int          n;
	logic [15:0] exp;

	scrc_regs #(.TICK_CYCLES(TICK), .WATCH_CYCLES(WATCH)) u_dut (
		.I_REF_CLK(clk), .I_SYS_RST(rst), .I_REQ(req), .I_CAL(cal),
		.I_STORED_STORED_CHECKSUM(stored), .I_ALARM(alarm), .I_OW_VALID_TXN(ow_txn),
		.O_RDATA(rdata), .O_RVALID(rvalid), .O_TURNAROUND_8BIT(dly8),
		.O_RUN_FROM_RAM(ram), .O_OTP_LOAD_REQ(load), .O_OTP_BANK(bank),
		.O_VOUT_EN(en), .O_FAULT_REF_SEL(fref), .O_FAULT_THR_SEL(fthr)
	);

	scrc_ctrl_model u_ctrl (.i_clk(clk), .o_req(req), .o_ow_valid_txn(ow_txn));

	// ==========================================
	// Helpers
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		u_ctrl.access(1'b1, a, d);
	endtask

	// Read strobe stands one cycle only, so it is sampled right here
	task automatic rd(input logic [3:0] a, input logic [15:0] want, input string name);
		u_ctrl.access(1'b0, a, 16'h0000);
		check("rvalid", {15'h0, rvalid}, 16'h0001);
		check(name, rdata, want);
	endtask

	task automatic wait_en(input logic lvl, output int k);
		k = 0;
		while (en !== lvl && k < 5000) begin
			@(negedge clk);
			k++;
		end
	endtask

	// End-around carry sum, inverted
	function automatic logic [15:0] csum(input logic [63:0] c);
		logic [16:0] t;
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			t = {1'b0, s} + {1'b0, c[63-16*i -: 16]};
			s = t[15:0] + {15'h0, t[16]};
		end
		return ~s;
	endfunction

	// Enable time measured from the write edge, one cycle latency allowed
	task automatic count_run(input logic [7:0] cnt);
		wr(`SCRC_ADDR_OUTEN, {8'h00, cnt});
		wait_en(1'b0, n);
		check("oe_time", {15'h0, n >= cnt * TICK - 1 && n <= cnt * TICK + 1}, 16'h0001);
	endtask

	// ==========================================
	// Clock, watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#1_000_000;
		miscompares++;
		summarize();
	end

	// ==========================================
	// Tests
	initial begin
		rst = 1'b1;
		cal = {16'hA5C3, 16'h7E19, 16'hEF0F, 16'hC171};
		stored = 16'h0000;
		alarm = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (16) @(negedge clk);
		check("en_rst", {15'h0, en}, 16'h0001);
		rst = 1'b0;
		rd(`SCRC_ADDR_CHKRB, 16'h0000, "chk_rst");
		rd(`SCRC_ADDR_SWCTL, 16'h0000, "sw_rst");
		rd(`SCRC_ADDR_OUTEN, 16'h0000, "cnt_rst");
		rd(`SCRC_ADDR_ALARM, 16'h0000, "alarm_rst");
		check("ram_rst", {15'h0, ram}, 16'h0000);

		exp = csum(cal);
		cyc(8);
		rd(`SCRC_ADDR_CHKRB, exp, "chk_sum");
		rd(`SCRC_ADDR_SWCTL, 16'h0000, "flag_bad");
		stored = exp;
		cyc(8);
		rd(`SCRC_ADDR_SWCTL, 16'h0100, "flag_ok");

		// Bank select under lock pattern, delay bit toggled
		for (int i = 0; i < 8; i++) begin
			wr(`SCRC_ADDR_SWCTL, {8'h00, i[0], 3'h5, 1'b0, i[2:0]});
			check("load", {15'h0, load}, {15'h0, i != 0});
			if (i != 0) check("bank", {13'h0, bank}, {13'h0, i[2:0]});
			cyc(1);
			check("ram", {15'h0, ram}, 16'h0001);
			check("dly", {15'h0, dly8}, {15'h0, i[0]});
			rd(`SCRC_ADDR_SWCTL, {8'h01, i[0], 3'h5, 1'b0, i[2:0]}, "sw_rb");
		end
		for (int j = 0; j < 8; j++) begin
			wr(`SCRC_ADDR_SWCTL, {9'h000, j[2:0], 4'h3});
			check("load_lk", {15'h0, load}, {15'h0, j == 5});
			cyc(1);
			check("ram_lk", {15'h0, ram}, {15'h0, j == 5});
		end

		// Alarm bits one at a time, then write and unmapped access
		for (int k = 0; k < 9; k++) begin
			alarm = scrc_alarm_t'(9'h001 << k);
			cyc(2);
			rd(`SCRC_ADDR_ALARM, 16'h0001 << k, "alarm");
		end
		wr(`SCRC_ADDR_ALARM, 16'hFFFF);
		rd(`SCRC_ADDR_ALARM, 16'h0100, "alarm_ro");
		rd(4'hF, 16'h0000, "unmapped");

		cal.fault_config_word = 16'h8000;
		cyc(2);
		check("fsel_a", {14'h0, fref, fthr}, 16'h0002);
		cal.fault_config_word = 16'h1000;
		cyc(2);
		check("fsel_b", {14'h0, fref, fthr}, 16'h0001);

		// Output enable counts, boundary values included
		count_run(8'h01);
		count_run(8'h03);
		count_run(8'hFF);
		wr(`SCRC_ADDR_OUTEN, 16'h0005);
		rd(`SCRC_ADDR_OUTEN, 16'h0005, "cnt_rb");
		check("en_cnt", {15'h0, en}, 16'h0001);
		wr(`SCRC_ADDR_OUTEN, 16'h0000);
		check("en_zero", {15'h0, en}, 16'h0000);
		repeat (4) begin
			cyc(WATCH - 10);
			u_ctrl.ping();
			check("en_quiet", {15'h0, en}, 16'h0000);
		end
		wait_en(1'b1, n);
		check("watch", {15'h0, n >= WATCH - 2 && n <= WATCH + 1}, 16'h0001);
		summarize();
	end
endmodule
